// ===== logic/isa_feature_id_pkg.sv
// constants for the instruction-set feature identification registers three and four
package isa_feature_id_pkg;

    // ========================================================================
    // coprocessor access selectors
    // ========================================================================
    localparam logic [2:0] SEL_OPC1      = 3'h0;
    localparam logic [3:0] SEL_CRN       = 4'h0;
    localparam logic [3:0] SEL_CRM       = 4'h2;
    localparam logic [2:0] SEL_OPC2_THREE = 3'h3;
    localparam logic [2:0] SEL_OPC2_FOUR  = 3'h4;

    // ========================================================================
    // field codes of register three
    // ========================================================================
    localparam logic [3:0] R3_EXEC_ENV   = 4'h1;
    localparam logic [3:0] R3_TRUE_NOP   = 4'h1;
    localparam logic [3:0] R3_COPY       = 4'h1;
    localparam logic [3:0] R3_TABLE_BR   = 4'h1;
    localparam logic [3:0] R3_SYNC_PRIM  = 4'h2;
    localparam logic [3:0] R3_SUPV_CALL  = 4'h1;
    localparam logic [3:0] R3_SIMD       = 4'h3;
    localparam logic [3:0] R3_SATURATE   = 4'h1;

    // ========================================================================
    // field codes of register four
    // ========================================================================
    localparam logic [7:0] R4_RESERVED   = 8'h00;
    localparam logic [3:0] R4_EXCLUSIVE  = 4'h0;
    localparam logic [3:0] R4_BARRIER    = 4'h1;
    localparam logic [3:0] R4_MON_CALL   = 4'h1;
    localparam logic [3:0] R4_WRITEBACK  = 4'h1;
    localparam logic [3:0] R4_WITH_SHIFT = 4'h4;
    localparam logic [3:0] R4_UNPRIV     = 4'h2;

    // ========================================================================
    // answer codes
    // ========================================================================
    typedef enum logic [1:0]
    {
        RESP_NONE  = 2'b00,
        RESP_DATA  = 2'b01,
        RESP_UNDEF = 2'b10
    } resp_t;

endpackage

// ===== logic/isa_feature_id_rom.sv
// constant word store holding both identification registers, registered read
`timescale 1ns/1ps
module isa_feature_id_rom
    import isa_feature_id_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        rd_en,
    input  wire logic        rd_sel_four,
    output logic      [31:0] rd_data
);
    // ========================================================================
    // hardwired words
    // ========================================================================
    // fields come straight from constants: no flop holds them, reset cannot touch them
    logic [31:0] word_three;
    logic [31:0] word_four;
    logic [31:0] rd_data_ff;

    assign word_three = {R3_EXEC_ENV,
                         R3_TRUE_NOP,
                         R3_COPY,
                         R3_TABLE_BR,
                         R3_SYNC_PRIM,
                         R3_SUPV_CALL,
                         R3_SIMD,
                         R3_SATURATE};
    assign word_four  = {R4_RESERVED,
                         R4_EXCLUSIVE,
                         R4_BARRIER,
                         R4_MON_CALL,
                         R4_WRITEBACK,
                         R4_WITH_SHIFT,
                         R4_UNPRIV};

    // ========================================================================
    // read port
    // ========================================================================
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rd_data_ff <= 32'h00000000;
        end
        else if (clk_en && rd_en)
        begin
            rd_data_ff <= rd_sel_four ? word_four : word_three;
        end
    end

    assign rd_data = rd_data_ff;
endmodule // isa_feature_id_rom

// ===== logic/isa_feature_id_regs_3_4.sv
// coprocessor access decode and answer for feature identification registers three and four
`timescale 1ns/1ps

// What this block does
// - register three is read-only, shared by both security states, privileged only.
// - register four is read-only, shared by both security states, privileged only.
// - privileged reads return data; writes and user-mode accesses raise undefined.
// - register three selected by opcode1 0, c0, c2, opcode2 3.
// - register four selected by opcode1 0, c0, c2, opcode2 4.
// - register three bits 31:28 read 0x1, execution environment extension.
// - register three bits 27:24 read 0x1, true no-operation support.
// - register three bits 23:20 read 0x1, low register copy.
// - register three bits 19:16 read 0x1, table branch.
// - register three bits 15:12 read 0x2, full exclusive set plus clear.
// - register three bits 11:8 read 0x1, supervisor call.
// - register three bits 7:4 read 0x3, packed SIMD and greater-equal flags.
// - register three bits 3:0 read 0x1, saturating arithmetic.
// - register four bits 23:20 read 0x0, bits 31:24 read zero.
// - register four bits 19:16 read 0x1, memory and sync barriers.
// - register four bits 15:12 read 0x1, secure monitor call.
// - register four bits 11:8 read 0x1, all write-back modes.
// - register four bits 7:4 read 0x4, shifted offsets and shifts.
// - register four bits 3:0 read 0x2, unprivileged load forms.
module isa_feature_id_regs_3_4
    import isa_feature_id_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        acc_valid,
    input  wire logic        acc_write,
    input  wire logic        acc_priv,
    input  wire logic        acc_secure,
    input  wire logic [2:0]  acc_opc1,
    input  wire logic [3:0]  acc_crn,
    input  wire logic [3:0]  acc_crm,
    input  wire logic [2:0]  acc_opc2,
    output logic             acc_hit,
    output logic             resp_valid,
    output logic             resp_undef,
    output logic      [31:0] resp_data
);
    // ========================================================================
    // local types and tables
    // ========================================================================
    // which of the two registers a request names
    typedef enum logic [1:0]
    {
        REG_NONE  = 2'b00,
        REG_THREE = 2'b01,
        REG_FOUR  = 2'b10
    } reg_sel_t;

    // privilege and direction of a request, before the register is known
    typedef enum logic [1:0]
    {
        CLASS_USER_READ  = 2'b00,
        CLASS_USER_WRITE = 2'b01,
        CLASS_PRIV_READ  = 2'b10,
        CLASS_PRIV_WRITE = 2'b11
    } acc_class_t;

    localparam int NUM_REGS   = 2;
    localparam int NUM_WORLDS = 2;

    // second opcode of each register, indexed like reg_hit
    localparam logic [2:0] OPC2_CODE [NUM_REGS] = '{SEL_OPC2_THREE, SEL_OPC2_FOUR};

    // ========================================================================
    // selector fields
    // ========================================================================
    logic                opc1_match;
    logic                crn_match;
    logic                crm_match;
    logic                group_match;
    logic [NUM_REGS-1:0] reg_hit;

    assign opc1_match  = (acc_opc1 == SEL_OPC1);
    assign crn_match   = (acc_crn == SEL_CRN);
    assign crm_match   = (acc_crm == SEL_CRM);
    // an idle cycle matches nothing, whatever the selectors hold
    assign group_match = acc_valid && opc1_match && crn_match && crm_match;

    genvar r;
    generate
        for (r = 0; r < NUM_REGS; r++)
        begin : g_reg
            assign reg_hit[r] = group_match && (acc_opc2 == OPC2_CODE[r]);
        end
    endgenerate

    // ========================================================================
    // register select
    // ========================================================================
    reg_sel_t reg_sel;

    always_comb
    begin
        if (reg_hit[0])
        begin
            reg_sel = REG_THREE;
        end
        else if (reg_hit[1])
        begin
            reg_sel = REG_FOUR;
        end
        else
        begin
            reg_sel = REG_NONE;
        end
    end

    // a miss leaves the request to the other identification registers
    assign acc_hit = (reg_sel != REG_NONE);

    // ========================================================================
    // access class
    // ========================================================================
    acc_class_t acc_class;

    always_comb
    begin
        case ({acc_priv, acc_write})
            2'h0:
            begin
                acc_class = CLASS_USER_READ;
            end
            2'h1:
            begin
                acc_class = CLASS_USER_WRITE;
            end
            2'h2:
            begin
                acc_class = CLASS_PRIV_READ;
            end
            default:
            begin
                acc_class = CLASS_PRIV_WRITE;
            end
        endcase
    end

    // ========================================================================
    // answer per register and security state
    // ========================================================================
    // each register keeps its own table with one slice per security state;
    // the slices agree, so either state sees the one shared copy
    resp_t reg_resp [NUM_REGS];

    genvar w;
    generate
        for (r = 0; r < NUM_REGS; r++)
        begin : g_table
            resp_t world_resp [NUM_WORLDS];

            for (w = 0; w < NUM_WORLDS; w++)
            begin : g_world
                resp_t slice_resp;

                always_comb
                begin
                    case (acc_class)
                        CLASS_PRIV_READ:
                        begin
                            slice_resp = RESP_DATA;
                        end
                        CLASS_PRIV_WRITE:
                        begin
                            slice_resp = RESP_UNDEF;
                        end
                        CLASS_USER_READ:
                        begin
                            slice_resp = RESP_UNDEF;
                        end
                        default:
                        begin
                            slice_resp = RESP_UNDEF;
                        end
                    endcase
                end

                assign world_resp[w] = slice_resp;
            end

            // the request's own security state picks its slice
            assign reg_resp[r] = reg_hit[r] ? world_resp[acc_secure] : RESP_NONE;
        end
    endgenerate

    // ========================================================================
    // next answer
    // ========================================================================
    resp_t nxt_resp;
    resp_t resp_ff;
    logic  rd_strobe;
    logic  rd_four;

    // at most one register hits, so the chain only orders the lookup
    always_comb
    begin
        if (reg_resp[0] != RESP_NONE)
        begin
            nxt_resp = reg_resp[0];
        end
        else if (reg_resp[1] != RESP_NONE)
        begin
            nxt_resp = reg_resp[1];
        end
        else
        begin
            nxt_resp = RESP_NONE;
        end
    end

    // the store is read only on a granted read: a refused request leaves the
    // data output as it was
    assign rd_strobe = (nxt_resp == RESP_DATA);
    assign rd_four   = (reg_sel == REG_FOUR);

    // ========================================================================
    // answer
    // ========================================================================
    // one-cycle latency keeps data and its strobe aligned with the registered store
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            resp_ff <= RESP_NONE;
        end
        else if (clk_en)
        begin
            resp_ff <= nxt_resp;
        end
    end

    // ========================================================================
    // word store
    // ========================================================================
    isa_feature_id_rom u_rom
    (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .clk_en      (clk_en),
        .rd_en       (rd_strobe),
        .rd_sel_four (rd_four),
        .rd_data     (resp_data)
    );

    // ========================================================================
    // outputs
    // ========================================================================
    assign resp_valid = (resp_ff != RESP_NONE);
    assign resp_undef = (resp_ff == RESP_UNDEF);
endmodule // isa_feature_id_regs_3_4

// ===== tb/isa_feature_id_regs_3_4_sva.sv
// checker for the feature identification register access port
`timescale 1ns/1ps
module isa_feature_id_regs_3_4_chk (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        clk_en,
    input wire logic        acc_valid,
    input wire logic        acc_write,
    input wire logic        acc_priv,
    input wire logic [2:0]  acc_opc1,
    input wire logic [3:0]  acc_crn,
    input wire logic [3:0]  acc_crm,
    input wire logic [2:0]  acc_opc2,
    input wire logic        acc_hit,
    input wire logic        resp_valid,
    input wire logic        resp_undef,
    input wire logic [31:0] resp_data
);
    // ========================================
    // properties
    // an attempt starting on the releasing edge would judge an answer that
    // the design still held in reset, so the first edge after release is skipped
    logic rst_hold_ff;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            rst_hold_ff <= 1'b1;
        else
            rst_hold_ff <= 1'b0;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst || rst_hold_ff);
    wire base = acc_valid && acc_opc1 == 3'h0 && acc_crn == 4'h0 && acc_crm == 4'h2;
    wire rd   = clk_en && base && !acc_write && acc_priv;
    AST_HIT: assert property (acc_hit == (base && (acc_opc2 == 3'h3 || acc_opc2 == 3'h4)))
        else $error("hit decode wrong");
    AST_ANSWER: assert property (clk_en && acc_hit |=> resp_valid)
        else $error("no answer to hit");
    AST_QUIET: assert property (clk_en && !acc_hit |=> !resp_valid)
        else $error("answer without hit");
    AST_UNDEF: assert property (clk_en && acc_hit && (acc_write || !acc_priv) |=> resp_undef)
        else $error("bad access not refused");
    AST_THREE: assert property (rd && acc_opc2 == 3'h3 |=> !resp_undef && resp_data == 32'h11112131)
        else $error("register three word wrong");
    AST_FOUR: assert property (rd && acc_opc2 == 3'h4 |=> !resp_undef && resp_data == 32'h00011142)
        else $error("register four word wrong");
    AST_FREEZE: assert property (!clk_en |=> $stable(resp_valid) && $stable(resp_data))
        else $error("state moved while frozen");
    AST_KEEP: assert property (resp_valid && resp_undef |-> $stable(resp_data))
        else $error("refused access changed data");
endmodule // isa_feature_id_regs_3_4_chk
bind isa_feature_id_regs_3_4 isa_feature_id_regs_3_4_chk chk
(
    .ref_clk    (ref_clk),
    .rst        (rst),
    .clk_en     (clk_en),
    .acc_valid  (acc_valid),
    .acc_write  (acc_write),
    .acc_priv   (acc_priv),
    .acc_opc1   (acc_opc1),
    .acc_crn    (acc_crn),
    .acc_crm    (acc_crm),
    .acc_opc2   (acc_opc2),
    .acc_hit    (acc_hit),
    .resp_valid (resp_valid),
    .resp_undef (resp_undef),
    .resp_data  (resp_data)
);

// ===== tb/isa_feature_id_regs_3_4_tb.sv
// random and corner-case bench for the feature identification registers
`timescale 1ns/1ps
module isa_feature_id_regs_3_4_tb;
    logic        ref_clk = 0, rst = 1, clk_en = 1, acc_valid = 0, acc_write = 0, acc_priv = 0;
    logic        acc_secure = 0, acc_hit, resp_valid, resp_undef, exp_valid = 0, exp_undef = 0;
    logic [2:0]  acc_opc1 = 0, acc_opc2 = 0;
    logic [3:0]  acc_crn = 0, acc_crm = 0;
    logic [31:0] resp_data, exp_data = 0;
    logic [18:0] f;
    int          fails = 0, samples_checked = 0, cycles = 0;
    wire sel = acc_valid && {acc_opc1, acc_crn, acc_crm} == 11'h002 && acc_opc2 inside {3, 4};
    isa_feature_id_regs_3_4 uut
    (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .clk_en     (clk_en),
        .acc_valid  (acc_valid),
        .acc_write  (acc_write),
        .acc_priv   (acc_priv),
        .acc_secure (acc_secure),
        .acc_opc1   (acc_opc1),
        .acc_crn    (acc_crn),
        .acc_crm    (acc_crm),
        .acc_opc2   (acc_opc2),
        .acc_hit    (acc_hit),
        .resp_valid (resp_valid),
        .resp_undef (resp_undef),
        .resp_data  (resp_data)
    );
    initial forever #4 ref_clk = ~ref_clk;
    // ========================================
    // expectation and checks
    function automatic logic [31:0] word_of(input logic [2:0] sel_two);
        return (sel_two == 3'h3) ? 32'h11112131 : 32'h00011142;
    endfunction
    task automatic check(input logic ok, input string what);
        samples_checked++;
        if (!ok)
        begin
            fails++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // model reads pre-edge inputs since the bench drives by nonblocking assignment
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (rst)
            {exp_valid, exp_undef, exp_data} = '0;
        else if (clk_en)
        begin
            exp_valid = sel;
            exp_undef = sel && (acc_write || !acc_priv);
            if (sel && !exp_undef)
                exp_data = word_of(acc_opc2);
        end
        if (cycles == 4000)
        begin
            fails++;
            end_of_test();
        end
    end
    always @(negedge ref_clk)
        if (!rst)
        begin
            check(acc_hit === sel, "hit");
            check({resp_valid, resp_undef} === {exp_valid, exp_undef}, "answer");
            check(resp_data === exp_data, "data");
        end
    // ========================================
    // stimulus
    task automatic drive(input logic [18:0] v);
        @(posedge ref_clk);
        {clk_en, acc_valid, acc_write, acc_priv, acc_secure, acc_opc1, acc_crn, acc_crm,
            acc_opc2} <= v;
    endtask
    initial
    begin
        void'($urandom(5658));
        repeat (12) @(posedge ref_clk);
        rst <= 0;
        for (int i = 0; i < 64; i++)
            drive({2'b11, i[5:3], 11'h002, i[2:0]});
        $display("test modes done");
        for (int i = 0; i < 2000; i++)
        begin
            f = 19'($urandom);
            if (i == 1000)
                rst <= 1;
            if (i == 1002)
                rst <= 0;
            if ($urandom % 4 != 0)
                f[13:3] = 11'h002;
            f[18] = ($urandom % 4 != 0);
            drive(f);
        end
        drive('0);
        drive('0);
        $display("test random done");
        end_of_test();
    end
endmodule // isa_feature_id_regs_3_4_tb
